// *** hw/dcsr_pkg.sv ***
package dcsr_pkg;
    // Timing at 200 MHz
    localparam int unsigned CLK_PERIOD_PS = 5000;
    localparam int unsigned BIT_PERIOD_US = 1000;
    localparam int unsigned SAMPLE_DELAY_US = 500;
    localparam int unsigned SAMPLE_DELAY_CYC =
        (SAMPLE_DELAY_US * 1000000) / CLK_PERIOD_PS;
    // Widths and counts
    localparam int unsigned DLY_W = 24;
    localparam int unsigned WORD_BITS = 8;
    localparam int unsigned LINE_BITS = 16;
    localparam int unsigned SEL_W = 4;
    localparam int unsigned BCNT_W = 5;
    localparam logic [BCNT_W-1:0] BCNT_RST = 5'h00;
    localparam logic [BCNT_W-1:0] WORD_DONE = 5'h08;
    localparam logic [BCNT_W-1:0] LINE_DONE = 5'h10;
    localparam logic [DLY_W-1:0] DLY_RST = 24'h000000;
    localparam logic [WORD_BITS-1:0] WORD_RST = 8'h00;
    localparam logic [LINE_BITS-1:0] LINE_RST = 16'h0000;
endpackage

// *** hw/dcsr_delay_line.sv ***
`timescale 1ns/1ps
`default_nettype none
// Sixteen-stage delay line with one fixed and two selectable taps
module dcsr_delay_line (
    input  wire logic                          clk_i,
    input  wire logic                          reset_i,
    input  wire logic                          shift_i,
    input  wire logic                          data_i,
    input  wire logic [dcsr_pkg::SEL_W-1:0]    sel_a_i,
    input  wire logic [dcsr_pkg::SEL_W-1:0]    sel_b_i,
    output logic                               last_stage_tap_o,
    output logic                               tap_a_o,
    output logic                               tap_b_o
);
    typedef struct packed {
        logic [dcsr_pkg::LINE_BITS-1:0] stages;
    } dcsr_line_s;

    dcsr_line_s st_q;
    dcsr_line_s st_d;

    // Shift in at stage zero
    always_comb begin
        st_d = st_q;
        if (shift_i) begin
            st_d.stages = {st_q.stages[dcsr_pkg::LINE_BITS-2:0], data_i};
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            st_q.stages <= dcsr_pkg::LINE_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // Taps; serial out from the last stage plus two selectable stages
    assign last_stage_tap_o = st_q.stages[dcsr_pkg::LINE_BITS-1];
    assign tap_a_o = st_q.stages[sel_a_i];
    assign tap_b_o = st_q.stages[sel_b_i];
endmodule
`default_nettype wire

// *** hw/dcsr_top.sv ***
// Function
// - A bit is low for a high pulse up to 1/5 period, high from 4/5.
// - Each line rise seen while idle starts a delay whose end samples the line.
// - With a 1 ms bit period the sample delay is 500 us.
// - The sample delay comes from a programmable count value.
// - Each sample into the shift register advances the bit counter.
// - After eight samples a single-cycle word-ready pulse is emitted.
// - The delay line is sixteen flops, serial out from the last one.
// - Two further delay line outputs each select any of the sixteen stages.
// - The delay line gives out its bits serially and through the two selectable taps.
// - Line clock muxes in a controller clock that shifts uncounted.
// - The delay line counter advances once per detected data bit.
// - At sixteen bits line-ready goes high and stays until the next data bit or an external counter reset.
// - Bit counters clear on power-on reset or an external reset.
`timescale 1ns/1ps
`default_nettype none
module dcsr_top #(
    parameter logic [dcsr_pkg::DLY_W-1:0] SAMPLE_DELAY =
        dcsr_pkg::DLY_W'(dcsr_pkg::SAMPLE_DELAY_CYC)
) (
    input  wire logic                          CLK_I,
    input  wire logic                          RESET_I,
    input  wire logic                          LINE_I,
    input  wire logic [dcsr_pkg::DLY_W-1:0]    DELAY_COUNT_I,
    input  wire logic                          USE_PARAM_DELAY_I,
    input  wire logic                          CNT_RESET_I,
    input  wire logic                          UNLOAD_CLK_I,
    input  wire logic [dcsr_pkg::SEL_W-1:0]    TAP_A_SEL_I,
    input  wire logic [dcsr_pkg::SEL_W-1:0]    TAP_B_SEL_I,
    output logic [dcsr_pkg::WORD_BITS-1:0]     WORD_O,
    output logic                               WORD_READY_O,
    output logic                               LINE_READY_O,
    output logic                               LAST_STAGE_TAP_O,
    output logic                               TAP_A_O,
    output logic                               TAP_B_O
);
    typedef enum logic [1:0] {
        DCSR_IDLE = 2'b01,
        DCSR_WAIT = 2'b10
    } dcsr_state_e;

    typedef struct packed {
        logic                          line_s1;
        logic                          line_s2;
        logic                          line_s3;
        logic                          clk_s1;
        logic                          clk_s2;
        logic                          clk_s3;
        logic                          cr_s1;
        logic                          cr_s2;
        dcsr_state_e                   state;
        logic [dcsr_pkg::DLY_W-1:0]    sample_delay_timer;
        logic [dcsr_pkg::WORD_BITS-1:0] word;
        logic [dcsr_pkg::BCNT_W-1:0]   word_cnt;
        logic [dcsr_pkg::BCNT_W-1:0]   line_cnt;
        logic                          word_ready;
        logic                          line_ready;
        logic                          sample;
        logic                          sample_val;
        logic                          last_tap;
        logic                          tap_a;
        logic                          tap_b;
    } dcsr_reg_s;

    dcsr_reg_s r_q;
    dcsr_reg_s r_d;

    logic line_rise;
    logic unload_rise;
    logic line_shift;
    logic line_data;
    logic [dcsr_pkg::DLY_W-1:0] dly_load;
    logic last_c;
    logic tap_a_c;
    logic tap_b_c;

    // Delay load with a floor of one cycle
    function automatic logic [dcsr_pkg::DLY_W-1:0] dcsr_floor1(
        input logic [dcsr_pkg::DLY_W-1:0] v
    );
        dcsr_floor1 = (v == dcsr_pkg::DLY_RST) ? dcsr_pkg::DLY_W'(1) : v;
    endfunction

    // Edges seen after two sync stages
    assign line_rise = r_q.line_s2 & ~r_q.line_s3;
    assign unload_rise = r_q.clk_s2 & ~r_q.clk_s3;
    assign dly_load = dcsr_floor1(USE_PARAM_DELAY_I ? SAMPLE_DELAY
                                                    : DELAY_COUNT_I);

    // Line clock: sample path or controller unload
    assign line_shift = r_q.sample | unload_rise;
    assign line_data = r_q.sample ? r_q.sample_val : 1'b0;

    // Next-state logic
    always_comb begin
        r_d = r_q;
        r_d.line_s1 = LINE_I;
        r_d.line_s2 = r_q.line_s1;
        r_d.line_s3 = r_q.line_s2;
        r_d.clk_s1 = UNLOAD_CLK_I;
        r_d.clk_s2 = r_q.clk_s1;
        r_d.clk_s3 = r_q.clk_s2;
        r_d.cr_s1 = CNT_RESET_I;
        r_d.cr_s2 = r_q.cr_s1;
        // Register the delay line taps
        r_d.last_tap = last_c;
        r_d.tap_a = tap_a_c;
        r_d.tap_b = tap_b_c;
        r_d.sample = 1'b0;
        r_d.word_ready = 1'b0;
        unique case (r_q.state)
            DCSR_IDLE: begin
                if (line_rise) begin
                    r_d.sample_delay_timer = dly_load;
                    r_d.state = DCSR_WAIT;
                end
            end
            DCSR_WAIT: begin
                if (r_q.sample_delay_timer == dcsr_pkg::DLY_W'(1)) begin
                    // Mid-period sample decides the bit value
                    r_d.sample = 1'b1;
                    r_d.sample_val = r_q.line_s2;
                    r_d.state = DCSR_IDLE;
                end else begin
                    r_d.sample_delay_timer =
                        r_q.sample_delay_timer - dcsr_pkg::DLY_W'(1);
                end
            end
        endcase
        // Count and capture on each sample
        if (r_q.sample) begin
            r_d.word = {r_q.word[dcsr_pkg::WORD_BITS-2:0], r_q.sample_val};
            if (r_q.word_cnt == dcsr_pkg::WORD_DONE - 5'h01) begin
                r_d.word_cnt = dcsr_pkg::BCNT_RST;
                r_d.word_ready = 1'b1;
            end else begin
                r_d.word_cnt = r_q.word_cnt + 5'h01;
            end
            r_d.line_ready = 1'b0;
            if (r_q.line_cnt == dcsr_pkg::LINE_DONE - 5'h01) begin
                r_d.line_cnt = dcsr_pkg::BCNT_RST;
                r_d.line_ready = 1'b1;
            end else begin
                r_d.line_cnt = r_q.line_cnt + 5'h01;
            end
        end
        // External counter reset; a same-cycle ready set wins
        if (r_q.cr_s2) begin
            r_d.word_cnt = dcsr_pkg::BCNT_RST;
            r_d.line_cnt = dcsr_pkg::BCNT_RST;
            r_d.line_ready = r_q.sample & r_d.line_ready;
        end
    end

    // State register; reset clears counters
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            r_q <= '0;
            r_q.state <= DCSR_IDLE;
            r_q.word_cnt <= dcsr_pkg::BCNT_RST;
            r_q.line_cnt <= dcsr_pkg::BCNT_RST;
            r_q.word <= dcsr_pkg::WORD_RST;
        end else begin
            r_q <= r_d;
        end
    end

    // Sixteen-stage serial line
    dcsr_delay_line u_line (
        .clk_i            (CLK_I),
        .reset_i          (RESET_I),
        .shift_i          (line_shift),
        .data_i           (line_data),
        .sel_a_i          (TAP_A_SEL_I),
        .sel_b_i          (TAP_B_SEL_I),
        .last_stage_tap_o (last_c),
        .tap_a_o          (tap_a_c),
        .tap_b_o          (tap_b_c)
    );

    // Outputs straight from flops; word readable in parallel
    assign WORD_O = r_q.word;
    assign WORD_READY_O = r_q.word_ready;
    assign LINE_READY_O = r_q.line_ready;
    assign LAST_STAGE_TAP_O = r_q.last_tap;
    assign TAP_A_O = r_q.tap_a;
    assign TAP_B_O = r_q.tap_b;

    // Ready pulse exactly one cycle wide
    a_ready_single: assert property (@(posedge CLK_I)
        disable iff (RESET_I) WORD_READY_O |=> !WORD_READY_O)
        else $error("ready too long");
    // Ready follows a sample
    a_ready_cause: assert property (@(posedge CLK_I)
        disable iff (RESET_I) $rose(WORD_READY_O) |-> $past(r_q.sample))
        else $error("ready without sample");
    // Sample follows delay wait
    a_sample_wait: assert property (@(posedge CLK_I)
        disable iff (RESET_I) r_q.sample |-> $past(r_q.state == DCSR_WAIT))
        else $error("sample outside wait");
    // Rising edge starts delay
    a_rise_start: assert property (@(posedge CLK_I)
        disable iff (RESET_I)
        (line_rise && r_q.state == DCSR_IDLE) |=> r_q.state == DCSR_WAIT)
        else $error("edge missed");
    // Line ready holds until next sample
    a_line_hold: assert property (@(posedge CLK_I)
        disable iff (RESET_I)
        (LINE_READY_O && !r_q.sample && !r_q.cr_s2) |=> LINE_READY_O)
        else $error("line ready dropped");
    // Unload shifts do not count
    a_unload_nocnt: assert property (@(posedge CLK_I)
        disable iff (RESET_I)
        (unload_rise && !r_q.sample && !r_q.cr_s2) |=> $stable(r_q.line_cnt))
        else $error("unload counted");
    // Counter reset clears counts
    a_cnt_clear: assert property (@(posedge CLK_I)
        disable iff (RESET_I)
        r_q.cr_s2 |=> (r_q.word_cnt == 5'h00 && r_q.line_cnt == 5'h00))
        else $error("count not cleared");
    // Counter advances per sample
    a_cnt_step: assert property (@(posedge CLK_I)
        disable iff (RESET_I)
        (r_q.sample && !r_q.cr_s2 && r_q.line_cnt != 5'h0f)
        |=> r_q.line_cnt == $past(r_q.line_cnt) + 5'h01)
        else $error("count step wrong");
    // Word shifts in each sampled bit, newest at bit zero
    a_word_shift: assert property (@(posedge CLK_I)
        disable iff (RESET_I) r_q.sample
        |=> WORD_O == {$past(WORD_O[dcsr_pkg::WORD_BITS-2:0]),
                       $past(r_q.sample_val)})
        else $error("word shift wrong");
endmodule
`default_nettype wire

// *** dv/dcsr_tx_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Duty-cycle transmitter and reading controller
module dcsr_tx_model #(
    parameter int PERIOD = 50
) (
    input  wire logic clk_i,
    output logic      line_o,
    output logic      unload_clk_o,
    output logic      cnt_reset_o
);
    int cyc = 0;
    int rise_cyc = 0;

    initial begin
        line_o = 1'b0;
        unload_clk_o = 1'b0;
        cnt_reset_o = 1'b0;
    end

    // Free-running cycle stamp for latency checks
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
    end

    // One period per bit, MSB first, line idles low
    task automatic send_bits(input logic [15:0] v, input int n);
        int hi;
        for (int i = n - 1; i >= 0; i--) begin
            hi = v[i] ? (PERIOD * 4) / 5 : PERIOD / 5;
            @(negedge clk_i);
            line_o = 1'b1;
            rise_cyc = cyc;
            repeat (hi) @(negedge clk_i);
            line_o = 1'b0;
            repeat (PERIOD - hi - 1) @(negedge clk_i);
        end
    endtask

    // Controller clock edge that unloads one bit
    task automatic unload_pulse();
        @(negedge clk_i);
        unload_clk_o = 1'b1;
        repeat (3) @(negedge clk_i);
        unload_clk_o = 1'b0;
        repeat (3) @(negedge clk_i);
    endtask

    // External counter clear before a new transfer
    task automatic cnt_clear();
        @(negedge clk_i);
        cnt_reset_o = 1'b1;
        repeat (3) @(negedge clk_i);
        cnt_reset_o = 1'b0;
        repeat (5) @(negedge clk_i);
    endtask
endmodule
`default_nettype wire

// *** dv/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam logic [23:0] N_PAR = 24'h000019;
    localparam logic [15:0] V16 = 16'ha53c;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        line;
    logic        unl;
    logic        crst;
    logic        use_p = 1'b1;
    logic [23:0] dly = 24'h00000c;
    logic [3:0]  sel_a = 4'h0;
    logic [3:0]  sel_b = 4'h0;
    logic [7:0]  word;
    logic        wrdy;
    logic        lrdy;
    logic        last;
    logic        tap_a;
    logic        tap_b;
    int          fails = 0;
    int          n_tests = 0;
    int          cycles = 0;
    int          nready = 0;
    int          rdy_cyc = 0;

    dcsr_tx_model u_dcsr_tx_model (.clk_i(clk), .line_o(line),
        .unload_clk_o(unl), .cnt_reset_o(crst));

    dcsr_top #(.SAMPLE_DELAY(N_PAR)) u_dcsr_top (.CLK_I(clk),
        .RESET_I(rst), .LINE_I(line), .DELAY_COUNT_I(dly),
        .USE_PARAM_DELAY_I(use_p), .CNT_RESET_I(crst),
        .UNLOAD_CLK_I(unl), .TAP_A_SEL_I(sel_a), .TAP_B_SEL_I(sel_b),
        .WORD_O(word), .WORD_READY_O(wrdy), .LINE_READY_O(lrdy),
        .LAST_STAGE_TAP_O(last), .TAP_A_O(tap_a), .TAP_B_O(tap_b));

    // Clock at 200 MHz
    initial begin
        forever #2.5 clk = ~clk;
    end

    // Ready pulse monitor and hang limit
    always @(posedge clk) begin
        cycles++;
        if (wrdy === 1'b1) begin
            nready++;
            rdy_cyc = u_dcsr_tx_model.cyc;
        end
        if (cycles == 6000) begin
            fails++;
            complete_run();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Ready must follow the last rise by delay plus pipeline
    task automatic chk_lat(input int n);
        int lat;
        lat = rdy_cyc - u_dcsr_tx_model.rise_cyc;
        chk(16'(lat >= n + 3 && lat <= n + 5), 16'h0001);
    endtask

    task automatic scen_word();
        u_dcsr_tx_model.send_bits(16'h00a5, 8);
        chk(16'(nready), 16'h0001);
        chk({8'h00, word}, 16'h00a5);
        chk_lat(25);
    endtask

    task automatic scen_line();
        u_dcsr_tx_model.send_bits(16'h003c, 8);
        chk(16'(nready), 16'h0002);
        chk({15'h0, lrdy}, 16'h0001);
        chk({15'h0, last}, {15'h0, V16[15]});
        for (int k = 0; k < 16; k++) begin
            @(negedge clk);
            sel_a = 4'(k);
            sel_b = 4'(15 - k);
            repeat (3) @(negedge clk);
            chk({15'h0, tap_a}, {15'h0, V16[k]});
            chk({15'h0, tap_b}, {15'h0, V16[15 - k]});
        end
    endtask

    task automatic scen_unload();
        for (int i = 0; i < 16; i++) begin
            chk({15'h0, last}, {15'h0, V16[15 - i]});
            u_dcsr_tx_model.unload_pulse();
        end
        chk({15'h0, lrdy}, 16'h0001);
        chk(16'(nready), 16'h0002);
        u_dcsr_tx_model.send_bits(16'h0001, 1);
        chk({15'h0, lrdy}, 16'h0000);
    endtask

    task automatic scen_clear();
        u_dcsr_tx_model.cnt_clear();
        @(negedge clk);
        use_p = 1'b0;
        u_dcsr_tx_model.send_bits(16'h004b, 7);
        chk(16'(nready), 16'h0002);
        u_dcsr_tx_model.send_bits(16'h0000, 1);
        chk(16'(nready), 16'h0003);
        chk({8'h00, word}, 16'h0096);
        chk_lat(12);
    endtask

    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (4) @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        scen_word();
        scen_line();
        scen_unload();
        scen_clear();
        complete_run();
    end
endmodule
`default_nettype wire
